// ---- logic/gbank_defines.vh ----
// Purpose: Shared constants for the DRAM bank-state and power-down tracker
// Assumes: 200 MHz core clock, commands sampled once per rising edge
// Notes: Times are in ns; cycle counts derive from them by rounding up
`ifndef GBANK_DEFINES_VH
`define GBANK_DEFINES_VH
`define GBANK_CLK_PERIOD_NS 5
`define GBANK_PRECHARGE_PERIOD_NS 15
`define GBANK_ACT_TO_ACCESS_NS 15
`define GBANK_REFRESH_CYCLE_NS 60
`define GBANK_MODE_LOAD_NS 10
`define GBANK_SELF_REFRESH_EXIT_NS 1000
`define GBANK_PD_EXIT_CYCLES 4
`define GBANK_BURST_CYCLES 2
`define GBANK_WRITE_RECOVERY_CYCLES 3
`define GBANK_CMD_DESELECT 4'h0
`define GBANK_CMD_NOP 4'h1
`define GBANK_CMD_ACTIVATE 4'h2
`define GBANK_CMD_REFRESH 4'h3
`define GBANK_CMD_LOAD_MODE 4'h4
`define GBANK_CMD_READ 4'h5
`define GBANK_CMD_WRITE 4'h6
`define GBANK_CMD_PRECHARGE 4'h7
`define GBANK_CMD_ILLEGAL 4'hF
`define GBANK_ST_IDLE 3'h0
`define GBANK_ST_ACTIVATING 3'h1
`define GBANK_ST_ACTIVE 3'h2
`define GBANK_ST_READING 3'h3
`define GBANK_ST_WRITING 3'h4
`define GBANK_ST_PRECHARGING 3'h5
`define GBANK_ST_READ_AUTO 3'h6
`define GBANK_ST_WRITE_AUTO 3'h7
`endif

// ---- logic/gbank_unit.v ----
// Purpose: One bank's state register and minimum-duration timer
// Assumes: Commands arrive already decoded and addressed to this bank
// Notes: Illegal commands for the current state are ignored
`timescale 1ns/1ps
`include "gbank_defines.vh"
module gbank_unit #(
  parameter TW = 8,
  parameter [TW-1:0] PRE_CYCLES = 8'h03,
  parameter [TW-1:0] ACT_CYCLES = 8'h03,
  parameter [TW-1:0] BURST_CYCLES = 8'h02,
  parameter [TW-1:0] WR_CYCLES = 8'h03
)
(
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Decoded commands for this bank
  input wire act_in,
  input wire read_in,
  input wire write_in,
  input wire pre_in,
  input wire auto_pre_in,
  // State
  output reg [2:0] state_out,
  output wire idle_out,
  output wire open_out
);
  reg [TW-1:0] timer;
  reg [2:0] next_state;
  reg [TW-1:0] next_timer;
  wire timer_done;

  assign timer_done = (timer <= {{(TW-1){1'b0}}, 1'b1});
  assign idle_out = (state_out == `GBANK_ST_IDLE);
  assign open_out = !idle_out && (state_out != `GBANK_ST_PRECHARGING);

  // Next-state logic per bank
  always @*
  begin
    next_state = state_out;
    next_timer = (timer == {TW{1'b0}}) ? timer : timer - {{(TW-1){1'b0}}, 1'b1};
    case (state_out)
      `GBANK_ST_IDLE:
      begin
        if (act_in)
        begin
          next_state = `GBANK_ST_ACTIVATING;
          next_timer = ACT_CYCLES;
        end
      end
      `GBANK_ST_ACTIVATING:
        if (timer_done)
          next_state = `GBANK_ST_ACTIVE;
      `GBANK_ST_ACTIVE, `GBANK_ST_READING, `GBANK_ST_WRITING:
      begin
        if (pre_in)
        begin
          next_state = `GBANK_ST_PRECHARGING;
          next_timer = PRE_CYCLES;
        end
        else if (read_in)
        begin
          next_state = auto_pre_in ? `GBANK_ST_READ_AUTO : `GBANK_ST_READING;
          next_timer = auto_pre_in ? BURST_CYCLES + PRE_CYCLES : BURST_CYCLES;
        end
        else if (write_in)
        begin
          next_state = auto_pre_in ? `GBANK_ST_WRITE_AUTO : `GBANK_ST_WRITING;
          next_timer = auto_pre_in ? BURST_CYCLES + WR_CYCLES + PRE_CYCLES : BURST_CYCLES;
        end
        else if ((state_out != `GBANK_ST_ACTIVE) && timer_done)
          next_state = `GBANK_ST_ACTIVE;
      end
      `GBANK_ST_PRECHARGING, `GBANK_ST_READ_AUTO, `GBANK_ST_WRITE_AUTO:
        if (timer_done)
          next_state = `GBANK_ST_IDLE;
      default:
        next_state = `GBANK_ST_IDLE;
    endcase
  end

  // State and timer registers
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state_out <= `GBANK_ST_IDLE;
      timer <= {TW{1'b0}};
    end
    else
    begin
      state_out <= next_state;
      timer <= next_timer;
    end
  end
endmodule

// ---- logic/gbank_tracker.v ----
// Purpose: Command decode, per-bank state tracking and power-down control
// Assumes: Command pins are synchronous to core_clk_in; only clock enable is treated as a pin input here
// Notes: Global refresh, mode-load and self-refresh exit windows hold off new commands
`timescale 1ns/1ps
`include "gbank_defines.vh"
module gbank_tracker #(
  parameter BANKS = 8,
  parameter BA_W = 3,
  parameter SELF_REFRESH_EXIT_NS = `GBANK_SELF_REFRESH_EXIT_NS
)
(
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Command pins, active low strobes
  input wire chip_select_n_in,
  input wire row_strobe_n_in,
  input wire col_strobe_n_in,
  input wire write_strobe_n_in,
  input wire clock_enable_in,
  input wire precharge_scope_bit_in,
  input wire [BA_W-1:0] bank_select_in,
  // Decoded command, one cycle pulses
  output reg [3:0] command_out,
  output reg command_valid_out,
  // Bank states, three bits each
  output wire [3*BANKS-1:0] bank_state_out,
  output wire all_idle_out,
  // Power states
  output reg precharge_power_down_out,
  output reg active_power_down_out,
  output reg self_refresh_out,
  output reg buffers_enabled_out,
  output reg global_busy_out
);
  // Cycle counts rounded up from ns figures
  localparam PRE_CYC = (`GBANK_PRECHARGE_PERIOD_NS + `GBANK_CLK_PERIOD_NS - 1) / `GBANK_CLK_PERIOD_NS;
  localparam ACT_CYC = (`GBANK_ACT_TO_ACCESS_NS + `GBANK_CLK_PERIOD_NS - 1) / `GBANK_CLK_PERIOD_NS;
  localparam RFC_CYC = (`GBANK_REFRESH_CYCLE_NS + `GBANK_CLK_PERIOD_NS - 1) / `GBANK_CLK_PERIOD_NS;
  localparam MRD_CYC = (`GBANK_MODE_LOAD_NS + `GBANK_CLK_PERIOD_NS - 1) / `GBANK_CLK_PERIOD_NS;
  localparam XSR_CYC = (SELF_REFRESH_EXIT_NS + `GBANK_CLK_PERIOD_NS - 1) / `GBANK_CLK_PERIOD_NS;
  localparam [11:0] PRE_W = PRE_CYC;
  localparam [11:0] RFC_W = RFC_CYC;
  localparam [11:0] MRD_W = MRD_CYC;
  localparam [11:0] XSR_W = XSR_CYC;
  localparam [11:0] PDX_W = `GBANK_PD_EXIT_CYCLES;

  // Power states, one-hot
  localparam [3:0] PS_ON = 4'h1;
  localparam [3:0] PS_PD = 4'h2;
  localparam [3:0] PS_SR = 4'h4;
  localparam [3:0] PS_EXIT = 4'h8;

  // Command decode from the four strobes
  function [3:0] gbank_decode;
    input cs_n;
    input ras_n;
    input cas_n;
    input we_n;
    begin
      case ({cs_n, ras_n, cas_n, we_n})
        4'h7: gbank_decode = `GBANK_CMD_NOP;
        4'h3: gbank_decode = `GBANK_CMD_ACTIVATE;
        4'h1: gbank_decode = `GBANK_CMD_REFRESH;
        4'h0: gbank_decode = `GBANK_CMD_LOAD_MODE;
        4'h5: gbank_decode = `GBANK_CMD_READ;
        4'h4: gbank_decode = `GBANK_CMD_WRITE;
        4'h2: gbank_decode = `GBANK_CMD_PRECHARGE;
        4'h6: gbank_decode = `GBANK_CMD_ILLEGAL;
        default: gbank_decode = `GBANK_CMD_DESELECT;
      endcase
    end
  endfunction

  // Clock enable synchroniser: three stages, change counted when last two agree
  reg cke_s1;
  reg cke_s2;
  reg cke_s3;
  reg cke_cur;
  reg cke_prev;
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      cke_s1 <= 1'b1;
      cke_s2 <= 1'b1;
      cke_s3 <= 1'b1;
      cke_cur <= 1'b1;
      cke_prev <= 1'b1;
    end
    else
    begin
      cke_s1 <= clock_enable_in;
      cke_s2 <= cke_s1;
      cke_s3 <= cke_s2;
      if (cke_s2 == cke_s3)
        cke_cur <= cke_s3;
      cke_prev <= cke_cur;
    end
  end

  // Command decode
  wire [3:0] cmd;
  wire is_nop;
  reg [3:0] pstate;
  reg [11:0] gtimer;
  wire exec_ok;
  assign cmd = gbank_decode(chip_select_n_in, row_strobe_n_in, col_strobe_n_in, write_strobe_n_in);
  assign is_nop = (cmd == `GBANK_CMD_NOP) || (cmd == `GBANK_CMD_DESELECT);
  // Commands only act in normal state with both samples high and no global hold-off, except refresh with clock enable falling, which enters self refresh
  assign exec_ok = (pstate == PS_ON) && cke_prev && cke_cur && (gtimer == 12'h000);

  // Per-bank command strobes
  wire [BANKS-1:0] bank_idle;
  wire [BANKS-1:0] bank_open;
  wire all_idle;
  wire pre_all;
  assign all_idle = &bank_idle;
  assign all_idle_out = all_idle;
  assign pre_all = exec_ok && (cmd == `GBANK_CMD_PRECHARGE) && precharge_scope_bit_in;

  genvar g;
  generate
    for (g = 0; g < BANKS; g = g + 1)
    begin : g_bank
      localparam [BA_W-1:0] BANK_ID = g;
      wire hit;
      assign hit = (bank_select_in == BANK_ID);
      gbank_unit #(
        .TW(8),
        .PRE_CYCLES(PRE_CYC[7:0]),
        .ACT_CYCLES(ACT_CYC[7:0]),
        .BURST_CYCLES(8'h02),
        .WR_CYCLES(8'h03)
      ) u_bank (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .act_in(exec_ok && hit && (cmd == `GBANK_CMD_ACTIVATE)),
        .read_in(exec_ok && hit && (cmd == `GBANK_CMD_READ)),
        .write_in(exec_ok && hit && (cmd == `GBANK_CMD_WRITE)),
        .pre_in(pre_all || (exec_ok && hit && (cmd == `GBANK_CMD_PRECHARGE) && !precharge_scope_bit_in)),
        .auto_pre_in(precharge_scope_bit_in),
        .state_out(bank_state_out[3*g+2:3*g]),
        .idle_out(bank_idle[g]),
        .open_out(bank_open[g])
      );
    end
  endgenerate

  // Legality of the command for the addressed bank; refused commands do not report as executed
  wire [2:0] sel_state;
  reg cmd_legal;
  assign sel_state = bank_state_out[3*bank_select_in +: 3];
  always @*
  begin
    case (cmd)
      `GBANK_CMD_ACTIVATE:
        cmd_legal = (sel_state == `GBANK_ST_IDLE);
      `GBANK_CMD_READ, `GBANK_CMD_WRITE:
        cmd_legal = (sel_state == `GBANK_ST_ACTIVE) || (sel_state == `GBANK_ST_READING) ||
          (sel_state == `GBANK_ST_WRITING);
      `GBANK_CMD_REFRESH, `GBANK_CMD_LOAD_MODE:
        cmd_legal = all_idle;
      `GBANK_CMD_PRECHARGE:
        cmd_legal = 1'b1;
      default:
        cmd_legal = 1'b0;
    endcase
  end

  // Power state machine and global hold-off timer
  reg [3:0] next_pstate;
  reg [11:0] next_gtimer;
  always @*
  begin
    next_pstate = pstate;
    next_gtimer = (gtimer == 12'h000) ? gtimer : gtimer - 12'h001;
    case (pstate)
      PS_ON:
      begin
        if (cke_prev && !cke_cur && cmd == `GBANK_CMD_REFRESH && all_idle)
          next_pstate = PS_SR;
        else if (cke_prev && !cke_cur && is_nop)
          next_pstate = PS_PD;
        else if (exec_ok && cmd == `GBANK_CMD_REFRESH && all_idle)
          next_gtimer = RFC_W;
        else if (exec_ok && cmd == `GBANK_CMD_LOAD_MODE && all_idle)
          next_gtimer = MRD_W;
        else if (pre_all)
          next_gtimer = PRE_W;
      end
      PS_PD:
        if (!cke_prev && cke_cur && is_nop)
        begin
          next_pstate = PS_EXIT;
          next_gtimer = PDX_W - 12'h001;
        end
      PS_SR:
        if (!cke_prev && cke_cur && is_nop)
        begin
          next_pstate = PS_EXIT;
          next_gtimer = XSR_W - 12'h001;
        end
      PS_EXIT:
        if (gtimer == 12'h000)
          next_pstate = PS_ON;
      default:
        next_pstate = PS_ON;
    endcase
  end

  // Registered power state and outputs
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      pstate <= PS_ON;
      gtimer <= 12'h000;
      command_out <= `GBANK_CMD_DESELECT;
      command_valid_out <= 1'b0;
      precharge_power_down_out <= 1'b0;
      active_power_down_out <= 1'b0;
      self_refresh_out <= 1'b0;
      buffers_enabled_out <= 1'b1;
      global_busy_out <= 1'b0;
    end
    else
    begin
      pstate <= next_pstate;
      gtimer <= next_gtimer;
      command_out <= cmd;
      command_valid_out <= exec_ok && cmd_legal;
      precharge_power_down_out <= (next_pstate == PS_PD) && all_idle;
      active_power_down_out <= (next_pstate == PS_PD) && !all_idle;
      self_refresh_out <= (next_pstate == PS_SR);
      // Only clock and clock enable stay live while powered down
      buffers_enabled_out <= !((next_pstate == PS_PD) || (next_pstate == PS_SR));
      global_busy_out <= (next_gtimer != 12'h000) || (next_pstate != PS_ON);
    end
  end
endmodule

// ---- tb/gbank_ctl_model.sv ----
// Purpose: Memory controller model driving command strobes and clock enable
// Assumes: Drives only after rising edges, one command then a nop edge
// Notes: Address lines show inverted junk once released
`timescale 1ns/1ps
`include "gbank_defines.vh"
module gbank_ctl_model (
  // Clock
  input wire core_clk_in,
  // Pins toward the device
  output reg [3:0] strobe_n_out,
  output reg scope_out,
  output reg [2:0] bank_out,
  output reg cke_out
);
  // Idle pins at time zero: nop, clock enable high
  initial
  begin
    strobe_n_out = 4'h7;
    scope_out = 1'b0;
    bank_out = 3'h0;
    cke_out = 1'b1;
  end
  // One command, then nop so each command is sampled on one edge only
  task issue(input [3:0] c, input [2:0] bk, input sc);
    reg [3:0] s;
    begin
      case (c)
        `GBANK_CMD_ACTIVATE: s = 4'h3;
        `GBANK_CMD_REFRESH: s = 4'h1;
        `GBANK_CMD_LOAD_MODE: s = 4'h0;
        `GBANK_CMD_READ: s = 4'h5;
        `GBANK_CMD_WRITE: s = 4'h4;
        `GBANK_CMD_PRECHARGE: s = 4'h2;
        default: s = 4'h7;
      endcase
      @(posedge core_clk_in);
      strobe_n_out <= s;
      bank_out <= bk;
      scope_out <= sc;
      @(posedge core_clk_in);
      strobe_n_out <= 4'h7;
      bank_out <= ~bk;
      scope_out <= ~sc;
    end
  endtask
  // Clock enable held at one level until told otherwise
  task set_cke(input v);
    begin
      @(posedge core_clk_in);
      cke_out <= v;
    end
  endtask
endmodule

// ---- tb/gbank_tracker_sva.sv ----
// Purpose: Port-level checks of decode, bank timers and power states
// Assumes: Bank 0 timers watched; other banks share the same logic
// Notes: Bounds are loose by one cycle where the hand-over gives none
`timescale 1ns/1ps
`include "gbank_defines.vh"
module gbank_tracker_sva #(
  parameter BANKS = 8
)
(
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Command pins
  input wire chip_select_n_in,
  input wire row_strobe_n_in,
  input wire col_strobe_n_in,
  input wire write_strobe_n_in,
  input wire precharge_scope_bit_in,
  // Outputs
  input wire [3:0] command_out,
  input wire command_valid_out,
  input wire [3*BANKS-1:0] bank_state_out,
  input wire all_idle_out,
  input wire precharge_power_down_out,
  input wire active_power_down_out,
  input wire self_refresh_out,
  input wire buffers_enabled_out,
  input wire global_busy_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Shorthands
  wire [3:0] strb = {chip_select_n_in, row_strobe_n_in, col_strobe_n_in, write_strobe_n_in};
  wire [2:0] b0 = bank_state_out[2:0];
  wire pd = precharge_power_down_out | active_power_down_out;
  wire exec = command_valid_out && command_out >= `GBANK_CMD_ACTIVATE && command_out <= `GBANK_CMD_PRECHARGE;
  reg any_open;
  integer i;
  // Any bank holding a row or a plain burst
  always @*
  begin
    any_open = 1'b0;
    for (i = 0; i < BANKS; i = i + 1)
      if (bank_state_out[3*i +: 3] >= `GBANK_ST_ACTIVE && bank_state_out[3*i +: 3] <= `GBANK_ST_WRITING)
        any_open = 1'b1;
  end
  sequence s_act_done;
    ##[1:4] b0 == `GBANK_ST_ACTIVE;
  endsequence
  sequence s_pre_done;
    ##[1:4] b0 == `GBANK_ST_IDLE;
  endsequence
  AST_ACT_DECODE: assert property (command_valid_out && command_out == `GBANK_CMD_ACTIVATE |-> $past(strb) == 4'h3)
    else $error("activate decoded from wrong strobes");
  AST_RD_DECODE: assert property (command_valid_out && command_out == `GBANK_CMD_READ |-> $past(strb) == 4'h5)
    else $error("read decoded from wrong strobes");
  AST_ACT_TIMER: assert property (b0 == `GBANK_ST_ACTIVATING && $past(b0) == `GBANK_ST_IDLE |-> s_act_done)
    else $error("bank 0 not active after activate delay");
  AST_PRE_TIMER: assert property (b0 == `GBANK_ST_PRECHARGING && $past(b0) != b0 |-> s_pre_done)
    else $error("bank 0 not idle after precharge period");
  AST_PRE_ALL: assert property (exec && command_out == `GBANK_CMD_PRECHARGE && $past(precharge_scope_bit_in)
    |-> !any_open)
    else $error("open bank left after precharge all");
  AST_PD_BUF: assert property (pd || self_refresh_out |-> !buffers_enabled_out)
    else $error("buffers on in power-down");
  AST_PPD_IDLE: assert property (precharge_power_down_out |-> all_idle_out && !active_power_down_out)
    else $error("precharge power-down with open bank");
  AST_APD_OPEN: assert property (active_power_down_out |-> !all_idle_out)
    else $error("active power-down with all banks idle");
  AST_PD_EXIT: assert property ($fell(pd) |-> !exec [*4])
    else $error("command run inside power-down exit window");
  AST_PD_HOLD: assert property (pd |-> !exec)
    else $error("command run in power-down");
  AST_REF_BUSY: assert property (exec && command_out == `GBANK_CMD_REFRESH |-> ##[0:1] global_busy_out)
    else $error("no hold-off after refresh");
endmodule
bind gbank_tracker gbank_tracker_sva #(.BANKS(BANKS)) i_sva (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .chip_select_n_in(chip_select_n_in), .row_strobe_n_in(row_strobe_n_in), .col_strobe_n_in(col_strobe_n_in),
  .write_strobe_n_in(write_strobe_n_in), .precharge_scope_bit_in(precharge_scope_bit_in),
  .command_out(command_out), .command_valid_out(command_valid_out), .bank_state_out(bank_state_out),
  .all_idle_out(all_idle_out), .precharge_power_down_out(precharge_power_down_out),
  .active_power_down_out(active_power_down_out), .self_refresh_out(self_refresh_out),
  .buffers_enabled_out(buffers_enabled_out), .global_busy_out(global_busy_out));

// ---- tb/gbank_tracker_test.sv ----
// Purpose: Self-checking bench of bank states, decode and power-down
// Assumes: Model waits out every timer before comparing bank states
// Notes: Self refresh entry is not exercised
`timescale 1ns/1ps
`include "gbank_defines.vh"
module gbank_tracker_test;
  reg core_clk_in;
  reg rst_in;
  wire [3:0] strb;
  wire scope, cke;
  wire [2:0] bank;
  wire [3:0] command_out;
  wire [23:0] bank_state_out;
  wire command_valid_out, all_idle_out, ppd, apd, buffers_on, sr, busy;
  integer n_fail = 0, tests_run = 0, hold = 0, pdm = 0, seed, k;
  integer mdl [0:7];
  integer bwait [0:7];
  reg [2:0] b1;
  gbank_ctl_model i_ctl (.core_clk_in(core_clk_in), .strobe_n_out(strb), .scope_out(scope), .bank_out(bank),
    .cke_out(cke));
  gbank_tracker #(.SELF_REFRESH_EXIT_NS(50)) i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .chip_select_n_in(strb[3]), .row_strobe_n_in(strb[2]), .col_strobe_n_in(strb[1]), .write_strobe_n_in(strb[0]),
    .clock_enable_in(cke), .precharge_scope_bit_in(scope), .bank_select_in(bank), .command_out(command_out),
    .command_valid_out(command_valid_out), .bank_state_out(bank_state_out), .all_idle_out(all_idle_out),
    .precharge_power_down_out(ppd), .active_power_down_out(apd), .self_refresh_out(sr),
    .buffers_enabled_out(buffers_on), .global_busy_out(busy));
  // 200 MHz clock
  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task cmp_flag(input got, input exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t flag got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cmp_cmd(input [3:0] got, input [3:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t command got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Every bank slice against the model
  task cmp_banks;
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1)
      begin
        tests_run = tests_run + 1;
        if (bank_state_out[3*j +: 3] !== mdl[j][2:0])
        begin
          n_fail = n_fail + 1;
          $display("[ERR] %0t bank %0d got %h exp %h", $time, j, bank_state_out[3*j +: 3], mdl[j][2:0]);
        end
      end
    end
  endtask
  // Issue one command, predict acceptance, then wait n cycles
  task run(input [3:0] c, input [2:0] bk, input sc, input integer n);
    reg t;
    integer j;
    begin
      t = (hold <= 0) && pdm == 0;
      if (c == `GBANK_CMD_ACTIVATE)
        t = t && mdl[bk] == `GBANK_ST_IDLE;
      if (c == `GBANK_CMD_READ || c == `GBANK_CMD_WRITE)
        t = t && mdl[bk] == `GBANK_ST_ACTIVE && bwait[bk] <= 0;
      for (j = 0; j < 8; j = j + 1)
        if (c == `GBANK_CMD_REFRESH || c == `GBANK_CMD_LOAD_MODE)
          t = t && mdl[j] == `GBANK_ST_IDLE;
      i_ctl.issue(c, bk, sc);
      #1;
      cmp_flag(command_valid_out, t);
      if (t)
        cmp_cmd(command_out, c);
      if (t && c == `GBANK_CMD_REFRESH)
        cmp_flag(busy, 1'b1);
      for (j = 0; j < 8; j = j + 1)
        if (t && (c == `GBANK_CMD_PRECHARGE && (sc || j == bk) || (c == `GBANK_CMD_READ
          || c == `GBANK_CMD_WRITE) && sc && j == bk))
          mdl[j] = `GBANK_ST_IDLE;
      if (t && c == `GBANK_CMD_ACTIVATE)
      begin
        mdl[bk] = `GBANK_ST_ACTIVE;
        // Access allowed one edge after the activate delay in whole cycles
        bwait[bk] = (`GBANK_ACT_TO_ACCESS_NS + `GBANK_CLK_PERIOD_NS - 1) / `GBANK_CLK_PERIOD_NS + 1;
      end
      if (t && c == `GBANK_CMD_REFRESH)
        hold = 14;
      if (t && c == `GBANK_CMD_LOAD_MODE)
        hold = 4;
      repeat (n) @(posedge core_clk_in);
      hold = hold - n - 2;
      for (j = 0; j < 8; j = j + 1)
        bwait[j] = bwait[j] - n - 2;
      if (n > 12)
        cmp_banks;
    end
  endtask
  task wait_pd(input v);
    begin
      for (k = 0; k < 40 && (apd | ppd) !== v; k = k + 1)
      begin
        @(posedge core_clk_in);
        #1;
      end
      if (k == 40)
      begin
        n_fail = n_fail + 1;
        print_verdict;
      end
    end
  endtask
  // Enter power-down, try a command, leave again
  task pd_test(input act_exp);
    begin
      i_ctl.set_cke(1'b0);
      wait_pd(1'b1);
      cmp_flag(apd, act_exp);
      cmp_flag(buffers_on, 1'b0);
      cmp_flag(sr, 1'b0);
      pdm = 1;
      run(`GBANK_CMD_ACTIVATE, b1 + 3'h1, 1'b0, 2);
      i_ctl.set_cke(1'b1);
      wait_pd(1'b0);
      pdm = 0;
      repeat (8) @(posedge core_clk_in);
      cmp_flag(buffers_on, 1'b1);
    end
  endtask
  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    for (k = 0; k < 8; k = k + 1)
    begin
      mdl[k] = `GBANK_ST_IDLE;
      bwait[k] = 0;
    end
    seed = $urandom(82293);
    b1 = $urandom % 8;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    cmp_banks;
    run(`GBANK_CMD_READ, b1, 1'b0, 16);
    run(`GBANK_CMD_ACTIVATE, b1, 1'b0, 16);
    run(`GBANK_CMD_WRITE, b1, 1'b0, 16);
    run(`GBANK_CMD_READ, b1, 1'b1, 16);
    run(`GBANK_CMD_ACTIVATE, b1, 1'b0, 1);
    run(`GBANK_CMD_READ, b1, 1'b0, 16);
    run(`GBANK_CMD_ACTIVATE, b1 ^ 3'h4, 1'b0, 16);
    run(`GBANK_CMD_PRECHARGE, b1, 1'b0, 16);
    pd_test(1'b1);
    run(`GBANK_CMD_REFRESH, b1, 1'b0, 16);
    run(`GBANK_CMD_PRECHARGE, $urandom % 8, 1'b1, 16);
    pd_test(1'b0);
    run(`GBANK_CMD_REFRESH, b1, 1'b0, 1);
    run(`GBANK_CMD_ACTIVATE, b1, 1'b0, 16);
    run(`GBANK_CMD_LOAD_MODE, b1, 1'b0, 16);
    print_verdict;
  end
endmodule
